// >>> design/spo_pkg.sv
package spo_pkg;

  // Register byte addresses on the AXI4-Lite slave
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RATE = 8'h04;
  localparam logic [7:0] REG_TARGET = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam logic [7:0] REG_ISTAT = 8'h14;
  localparam logic [7:0] REG_IMASK = 8'h18;

  // Control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_UP_ASG = 1;
  localparam int CTRL_DN_ASG = 2;
  localparam int CTRL_WIDE = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h6;

  // Status register fields
  localparam int SB_SENDING = 0;
  localparam int SB_DONE = 1;
  localparam int SB_ERR = 2;
  localparam int SB_HEADING = 3;

  // Interrupt status and mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;

  // Legal operand ranges and reset values
  localparam logic [15:0] RATE_RESET = 16'h0064;
  localparam logic [15:0] RATE_MIN = 16'h0008;
  localparam logic [15:0] RATE_MAX = 16'h07D0;
  localparam logic [31:0] TGT_MAX_NARROW = 32'h0000_7FFF;
  localparam logic [31:0] TGT_MAX_WIDE = 32'h7FFF_FFFF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reference timebase: the system clock itself
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned REF_HZ = NS_PER_S / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_DONE = 4'h4,
    ST_FAULT = 4'h8
  } spo_state_e;

  typedef struct packed {
    logic [2:0] en_s;
    logic [2:0] pau_s;
    logic [2:0] ud_s;
    logic en_f;
    logic pau_f;
    logic ud_f;
    logic en_prev;
    spo_state_e st;
    logic dir;
    logic level;
    logic [31:0] acc;
    logic [31:0] count;
    logic sending;
    logic done;
    logic err;
    logic up_o;
    logic dn_o;
    logic step_o;
    logic head_o;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] rate;
    logic [31:0] target;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic irq;
    logic aw_rdy;
    logic aw_have;
    logic [AXI_AW-1:0] awaddr;
    logic w_rdy;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } spo_regs_s;

  localparam spo_regs_s SPO_RESET = '{
    st: ST_IDLE,
    ctrl: CTRL_RESET,
    rate: RATE_RESET,
    default: '0
  };

endpackage : spo_pkg

// >>> design/spo_pulse_out.sv
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps

// Overview of operation
// - A rising edge of the enable input restarts the block, clearing done and the count; sending then rises unless paused or faulted.
// - At that restart the rate and target are taken up and the direction input is sampled.
// - After restart nothing happens while paused, else 50% duty pulses go to up or down output.
// - Each pulse sent adds one to the emitted count, unless the target is zero.
// - Sending stops once the count reaches or passes the target, and done is then set.
// - The sending flag is high exactly while pulses are being transmitted.
// - Enable falling mid-run stops pulses, output low, and clears sending; all else is kept.
// - Pause holds output low and sending clear, keeps all state, then resumes where it left.
// - Rate and target are followed live while the run is not finished.
// - Direction is sampled only at restart and later changes of its input are ignored.
// - With only one of the up or down outputs assigned, every pulse goes to that one.
// - In mode one pulses appear on the step output and heading shows 1 for up, 0 for down.
// - Targets of 0 to 32767 (narrow) or 0 to 2147483647 (wide) are accepted.
// - A target of zero runs endlessly with count and done held at zero.
// - Rates of 8 to 2000 are accepted.
// - A target or rate out of range keeps the block from running and raises the error flag.
module spo_pulse_out
  import spo_pkg::*;
#(
  parameter int unsigned REF_CLK_HZ = REF_HZ
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic EN_IN,
  input wire logic PAUSE_IN,
  input wire logic UPDOWN_IN,
  output logic UP_PULSE_OUT,
  output logic DOWN_PULSE_OUT,
  output logic STEP_OUT,
  output logic HEADING_OUT,
  output logic SENDING_OUT,
  output logic DONE_FLAG,
  output logic ERROR_FLAG,
  output logic IRQ,
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // Accumulator adds twice the rate; the reference must outrun that and fit 31 bits
  if (REF_CLK_HZ < 2 * RATE_MAX || REF_CLK_HZ > 32'h7FFF_FFFF) begin : g_bad_ref
    $error("REF_CLK_HZ out of the range the rate accumulator serves");
  end

  localparam logic [31:0] REF_STEP = 32'(REF_CLK_HZ);

  spo_regs_s r_q;
  spo_regs_s r_d;
  logic start;
  logic rate_ok;
  logic tgt_ok;
  logic run_vis;
  logic lvl;
  logic eff_up;
  logic [31:0] acc_sum;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // Merge write data into a register under the byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  // Read mux; unmapped addresses answer zero
  function automatic logic [31:0] read_reg(input spo_regs_s s, input logic [AXI_AW-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      REG_CTRL: v[CTRL_W-1:0] = s.ctrl;
      REG_RATE: v[15:0] = s.rate;
      REG_TARGET: v = s.target;
      REG_STATUS: begin
        v[SB_SENDING] = s.sending;
        v[SB_DONE] = s.done;
        v[SB_ERR] = s.err;
        v[SB_HEADING] = s.dir;
      end
      REG_COUNT: v = s.count;
      REG_ISTAT: v[IRQ_W-1:0] = s.istat;
      REG_IMASK: v[IRQ_W-1:0] = s.imask;
      default: v = '0;
    endcase
    return v;
  endfunction : read_reg

  function automatic logic addr_mapped(input logic [AXI_AW-1:0] a);
    return a == REG_CTRL || a == REG_RATE || a == REG_TARGET || a == REG_STATUS ||
           a == REG_COUNT || a == REG_ISTAT || a == REG_IMASK;
  endfunction : addr_mapped

  // Next-state logic for the whole block
  always_comb begin
    r_d = r_q;
    irq_clr = '0;
    acc_sum = '0;

    // Pins pass three flops; a change counts once the last two agree
    r_d.en_s = {r_q.en_s[1:0], EN_IN};
    r_d.pau_s = {r_q.pau_s[1:0], PAUSE_IN};
    r_d.ud_s = {r_q.ud_s[1:0], UPDOWN_IN};
    if (r_q.en_s[1] == r_q.en_s[2]) begin
      r_d.en_f = r_q.en_s[2];
    end
    if (r_q.pau_s[1] == r_q.pau_s[2]) begin
      r_d.pau_f = r_q.pau_s[2];
    end
    if (r_q.ud_s[1] == r_q.ud_s[2]) begin
      r_d.ud_f = r_q.ud_s[2];
    end
    r_d.en_prev = r_q.en_f;
    start = r_q.en_f & ~r_q.en_prev;

    // Operand range checks, live so that edits mid-run are also policed
    rate_ok = (r_q.rate >= RATE_MIN) && (r_q.rate <= RATE_MAX);
    tgt_ok = r_q.ctrl[CTRL_WIDE] ? (r_q.target <= TGT_MAX_WIDE)
                                 : (r_q.target <= TGT_MAX_NARROW);

    // Pulse sequencer
    case (r_q.st)
      ST_IDLE, ST_DONE, ST_FAULT: begin
        r_d.st = r_q.st;
      end
      ST_RUN: begin
        if (!r_q.en_f) begin
          r_d.st = ST_IDLE;
        end else if (!(rate_ok && tgt_ok)) begin
          r_d.st = ST_FAULT;
          r_d.err = 1'b1;
        end else if (!r_q.pau_f) begin
          // Completion is judged only between pulses so the last one stays whole
          if (!r_q.level && r_q.target != '0 && r_q.count >= r_q.target) begin
            r_d.st = ST_DONE;
            r_d.done = 1'b1;
          end else begin
            // Phase accumulator: two toggles per period at the live rate in hertz
            acc_sum = r_q.acc + {15'h0000, r_q.rate, 1'b0};
            if (acc_sum >= REF_STEP) begin
              r_d.acc = acc_sum - REF_STEP;
              r_d.level = ~r_q.level;
              if (!r_q.level && r_q.target != '0) begin
                r_d.count = r_q.count + 32'h0000_0001;
              end
            end else begin
              r_d.acc = acc_sum;
            end
          end
        end
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase

    // Restart on enable rising: clear, sample direction, check operands
    if (start) begin
      r_d.count = '0;
      r_d.done = 1'b0;
      r_d.level = 1'b0;
      r_d.acc = '0;
      r_d.dir = r_q.ud_f;
      r_d.err = ~(rate_ok && tgt_ok);
      r_d.st = (rate_ok && tgt_ok) ? ST_RUN : ST_FAULT;
    end

    // Pin drive; pause and idle both hold the line low
    run_vis = (r_d.st == ST_RUN) && !r_q.pau_f;
    lvl = run_vis & r_d.level;
    r_d.sending = run_vis;
    case ({r_q.ctrl[CTRL_UP_ASG], r_q.ctrl[CTRL_DN_ASG]})
      2'b10: eff_up = 1'b1;
      2'b01: eff_up = 1'b0;
      default: eff_up = r_d.dir;
    endcase
    r_d.up_o = lvl & ~r_q.ctrl[CTRL_MODE] & eff_up;
    r_d.dn_o = lvl & ~r_q.ctrl[CTRL_MODE] & ~eff_up;
    r_d.step_o = lvl & r_q.ctrl[CTRL_MODE];
    r_d.head_o = r_q.ctrl[CTRL_MODE] & r_d.dir;

    // Write channel: address and data taken in either order
    if (r_q.bvalid && S_AXI_BREADY) begin
      r_d.bvalid = 1'b0;
    end
    if (r_q.aw_rdy && S_AXI_AWVALID) begin
      r_d.aw_have = 1'b1;
      r_d.awaddr = S_AXI_AWADDR;
    end
    if (r_q.w_rdy && S_AXI_WVALID) begin
      r_d.w_have = 1'b1;
      r_d.wdata = S_AXI_WDATA;
      r_d.wstrb = S_AXI_WSTRB;
    end
    if (r_d.aw_have && r_d.w_have && !r_q.bvalid) begin
      r_d.aw_have = 1'b0;
      r_d.w_have = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = addr_mapped(r_d.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (r_d.awaddr)
        REG_CTRL: r_d.ctrl = CTRL_W'(strb_merge(32'(r_q.ctrl), r_d.wdata, r_d.wstrb));
        REG_RATE: r_d.rate = 16'(strb_merge(32'(r_q.rate), r_d.wdata, r_d.wstrb));
        REG_TARGET: r_d.target = strb_merge(r_q.target, r_d.wdata, r_d.wstrb);
        REG_ISTAT: irq_clr = IRQ_W'(strb_merge(32'h0000_0000, r_d.wdata, r_d.wstrb));
        REG_IMASK: r_d.imask = IRQ_W'(strb_merge(32'(r_q.imask), r_d.wdata, r_d.wstrb));
        default: r_d.bvalid = 1'b1;
      endcase
    end
    r_d.aw_rdy = ~r_d.aw_have & ~r_d.bvalid;
    r_d.w_rdy = ~r_d.w_have & ~r_d.bvalid;

    // Read channel: one read at a time, answered the cycle after the address
    if (r_q.rvalid && S_AXI_RREADY) begin
      r_d.rvalid = 1'b0;
    end
    if (r_q.ar_rdy && S_AXI_ARVALID) begin
      r_d.rvalid = 1'b1;
      r_d.rdata = read_reg(r_q, S_AXI_ARADDR);
      r_d.rresp = addr_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    r_d.ar_rdy = ~r_d.rvalid;

    // Sticky events; a new event beats a write-one-to-clear in the same cycle
    irq_set[IRQ_DONE] = r_d.done & ~r_q.done;
    irq_set[IRQ_ERR] = r_d.err & ~r_q.err;
    r_d.istat = (r_q.istat & ~irq_clr) | irq_set;
    r_d.irq = |(r_d.istat & r_d.imask);
  end

  // State register
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      r_q <= SPO_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // Every output straight from the state register
  assign UP_PULSE_OUT = r_q.up_o;
  assign DOWN_PULSE_OUT = r_q.dn_o;
  assign STEP_OUT = r_q.step_o;
  assign HEADING_OUT = r_q.head_o;
  assign SENDING_OUT = r_q.sending;
  assign DONE_FLAG = r_q.done;
  assign ERROR_FLAG = r_q.err;
  assign IRQ = r_q.irq;
  assign S_AXI_AWREADY = r_q.aw_rdy;
  assign S_AXI_WREADY = r_q.w_rdy;
  assign S_AXI_BVALID = r_q.bvalid;
  assign S_AXI_BRESP = r_q.bresp;
  assign S_AXI_ARREADY = r_q.ar_rdy;
  assign S_AXI_RVALID = r_q.rvalid;
  assign S_AXI_RDATA = r_q.rdata;
  assign S_AXI_RRESP = r_q.rresp;

  // Checks on the sequencer
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // Restart strobe rebuilt from registered state for the checks
  logic start_q;
  assign start_q = r_q.en_f & ~r_q.en_prev;

  a_idle_quiet: assert property (
    !SENDING_OUT |-> !(UP_PULSE_OUT || DOWN_PULSE_OUT || STEP_OUT))
    else $error("Pulse output high while not sending");

  a_pause_holds: assert property (
    (r_q.pau_f && r_q.st == ST_RUN) |=> !SENDING_OUT && $stable(r_q.count) && $stable(r_q.acc))
    else $error("Pause did not freeze the run");

  a_enable_drop: assert property (
    (!r_q.en_f && r_q.st == ST_RUN) |=> r_q.st == ST_IDLE && !SENDING_OUT && $stable(r_q.count))
    else $error("Enable drop did not stop cleanly");

  // Sending is already low when a restart is seen, since restarts only leave idle states
  a_restart_clears: assert property (
    start_q |-> !SENDING_OUT ##1 (r_q.count == '0 && !DONE_FLAG))
    else $error("Restart did not clear count and flags");

  a_count_step: assert property (
    ($changed(r_q.count) && !$past(start_q)) |-> r_q.count == $past(r_q.count) + 32'h0000_0001)
    else $error("Count moved by other than one");

  a_done_cause: assert property (
    $rose(DONE_FLAG) |-> $past(r_q.count) >= $past(r_q.target) && $past(r_q.target) != '0
                      ##1 !SENDING_OUT [*2])
    else $error("Done set before the target was met");

  a_endless_run: assert property (
    (r_q.st == ST_RUN && r_q.target == '0 && r_q.count == '0) |=> r_q.count == '0 && !DONE_FLAG)
    else $error("Endless run moved count or done");

  a_bad_rate: assert property (
    (start_q && (r_q.rate < RATE_MIN || r_q.rate > RATE_MAX)) |=> ERROR_FLAG && !SENDING_OUT)
    else $error("Out of range rate was not refused");

  a_dir_hold: assert property (
    (r_q.st == ST_RUN && !start_q) |=> $stable(r_q.dir) || $past(start_q))
    else $error("Direction changed mid-run");

  a_step_mode: assert property (
    $past(r_q.ctrl[CTRL_MODE]) |-> !UP_PULSE_OUT && !DOWN_PULSE_OUT)
    else $error("Up or down line pulsed in step mode");

  // Operand policing at restart and mid-run
  a_good_start: assert property (
    (start_q && rate_ok && tgt_ok && !r_q.pau_f) |=> SENDING_OUT && !ERROR_FLAG)
    else $error("In range operands did not start a run");

  a_narrow_tgt: assert property (
    (start_q && !r_q.ctrl[CTRL_WIDE] && r_q.target > TGT_MAX_NARROW) |=> ERROR_FLAG)
    else $error("Narrow target above its limit was accepted");

  a_wide_tgt: assert property (
    (start_q && r_q.ctrl[CTRL_WIDE] && r_q.target > TGT_MAX_WIDE) |=> ERROR_FLAG)
    else $error("Wide target above its limit was accepted");

  a_live_fault: assert property (
    (r_q.st == ST_RUN && r_q.en_f && !(rate_ok && tgt_ok)) |=> ERROR_FLAG && !SENDING_OUT)
    else $error("Operand made bad mid-run did not stop the run");

  a_error_idle: assert property (
    ERROR_FLAG |-> !SENDING_OUT)
    else $error("Pulses sent while the error flag is set");

  // Direction, single-output and phase bookkeeping
  a_dir_sample: assert property (
    start_q |=> r_q.dir == $past(r_q.ud_f))
    else $error("Direction not taken at restart");

  a_up_only: assert property (
    ($past(r_q.ctrl[CTRL_UP_ASG]) && !$past(r_q.ctrl[CTRL_DN_ASG])) |-> !DOWN_PULSE_OUT)
    else $error("Down line pulsed with only the up output assigned");

  a_down_only: assert property (
    (!$past(r_q.ctrl[CTRL_UP_ASG]) && $past(r_q.ctrl[CTRL_DN_ASG])) |-> !UP_PULSE_OUT)
    else $error("Up line pulsed with only the down output assigned");

  // The phase must stay below one reference step or a toggle would be lost
  a_phase_bound: assert property (
    r_q.acc < REF_STEP)
    else $error("Phase accumulator left its range");

  // Main scenarios the bench is expected to reach
  c_run_start: cover property (start_q ##1 SENDING_OUT);
  c_done: cover property ($rose(DONE_FLAG));
  c_pause_resume: cover property (SENDING_OUT ##1 !SENDING_OUT && r_q.pau_f ##[1:50] SENDING_OUT);
  c_error: cover property ($rose(ERROR_FLAG));
  c_endless: cover property (SENDING_OUT && r_q.target == '0 && r_q.level);

endmodule : spo_pulse_out

// >>> testbench/spo_motor_drv.sv
`timescale 1ns/1ps

// Stepper driver stand-in: tracks shaft position and the width of the last pulse
module spo_motor_drv (
  input wire logic clk,
  input wire logic resetn,
  input wire logic up_p,
  input wire logic dn_p,
  input wire logic step_p,
  input wire logic head,
  output int pos,
  output int high_w
);
  logic up_q, dn_q, st_q;
  int run_q;
  // A step moves the shaft the way the heading line points at its rising edge
  always_ff @(posedge clk) begin
    up_q <= up_p;
    dn_q <= dn_p;
    st_q <= step_p;
    if (!resetn) begin
      pos <= 0;
      high_w <= 0;
      run_q <= 0;
    end else begin
      pos <= pos + int'(up_p && !up_q) - int'(dn_p && !dn_q)
        + ((step_p && !st_q) ? (head ? 1 : -1) : 0);
      run_q <= (up_p | dn_p | step_p) ? run_q + 1 : 0;
      if (!(up_p | dn_p | step_p) && run_q != 0) begin
        high_w <= run_q;
      end
    end
  end
endmodule : spo_motor_drv

// >>> testbench/stepper_pulse_output_tb.sv
`timescale 1ns/1ps

module stepper_pulse_output_tb;
  import spo_pkg::*;
  logic clk, rstn, en, pause_in, ud, up, dn, stp, hd, snd, done, err, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int pos, hw, p0, n_errors, checks;

  // Small timebase so a 2000 Hz rate gives 10-clock half periods
  spo_pulse_out #(.REF_CLK_HZ(40000)) spo_pulse_out_inst (
    .CLK(clk), .RESETN(rstn), .EN_IN(en), .PAUSE_IN(pause_in), .UPDOWN_IN(ud),
    .UP_PULSE_OUT(up), .DOWN_PULSE_OUT(dn), .STEP_OUT(stp), .HEADING_OUT(hd),
    .SENDING_OUT(snd), .DONE_FLAG(done), .ERROR_FLAG(err), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );

  spo_motor_drv spo_motor_drv_inst (
    .clk(clk), .resetn(rstn), .up_p(up), .dn_p(dn), .step_p(stp), .head(hd),
    .pos(pos), .high_w(hw)
  );

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic bail(input string nm);
    n_errors++;
    $display("unexpected %s exp answer seen timeout", nm);
    report_and_stop();
  endtask : bail

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) bail("bvalid");
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) bail("rvalid");
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axr

  // Enable is dropped long enough for the synchroniser to see a fresh rising edge
  task automatic run(input logic [3:0] c, input logic [15:0] r, input logic [31:0] t,
                     input logic u);
    axw(REG_CTRL, {28'h0, c});
    axw(REG_RATE, {16'h0, r});
    axw(REG_TARGET, t);
    ud <= u;
    en <= 1'b0;
    repeat (8) @(posedge clk);
    p0 = pos;
    en <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : run

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) bail("done_flag");
  endtask : wait_done

  task automatic t_regs();
    axr(REG_CTRL);
    chk("ctrl reset", rd, {28'h0, CTRL_RESET});
    axr(REG_RATE);
    chk("rate reset", rd, {16'h0, RATE_RESET});
    axr(REG_IMASK);
    chk("imask reset", rd, 32'h0);
    axr(8'h1C);
    chk("unmapped rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    axw(8'h1C, 32'hFFFF_FFFF);
    chk("unmapped bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    $display("test regs done");
  endtask : t_regs

  task automatic t_basic();
    axw(REG_IMASK, 32'h3);
    run(CTRL_RESET, RATE_MAX, 32'h3, 1'b1);
    chk("sending", snd, 1'b1);
    wait_done();
    chk("sending end", snd, 1'b0);
    chk("up pulses", pos - p0, 3);
    chk("high width", hw, 10);
    axr(REG_COUNT);
    chk("count", rd, 32'h3);
    chk("irq done", irq, 1'b1);
    axw(REG_ISTAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 1'b0);
    run(CTRL_RESET, RATE_MAX, 32'h2, 1'b0);
    chk("done cleared", done, 1'b0);
    ud <= 1'b1;
    wait_done();
    chk("down pulses", pos - p0, -2);
    axr(REG_STATUS);
    chk("sampled dir", rd[SB_HEADING], 1'b0);
    $display("test basic done");
  endtask : t_basic

  task automatic t_outputs();
    for (int i = 0; i < 2; i++) begin
      run(CTRL_RESET | 4'h1, RATE_MAX, 32'h2, i[0]);
      chk("heading", hd, i[0]);
      wait_done();
      chk("step pulses", pos - p0, i ? 2 : -2);
    end
    run(4'h2, RATE_MAX, 32'h2, 1'b0);
    wait_done();
    chk("up only", pos - p0, 2);
    run(4'h4, RATE_MAX, 32'h2, 1'b1);
    wait_done();
    chk("down only", pos - p0, -2);
    $display("test outputs done");
  endtask : t_outputs

  task automatic t_hold();
    logic [31:0] c;
    run(CTRL_RESET, RATE_MAX, 32'h4, 1'b1);
    repeat (25) @(posedge clk);
    pause_in <= 1'b1;
    repeat (8) @(posedge clk);
    chk("paused sending", snd, 1'b0);
    chk("paused line", up, 1'b0);
    axr(REG_COUNT);
    c = rd;
    repeat (60) @(posedge clk);
    axr(REG_COUNT);
    chk("count frozen", rd, c);
    pause_in <= 1'b0;
    wait_done();
    axr(REG_COUNT);
    chk("count resumed", rd, 32'h4);
    run(CTRL_RESET, RATE_MAX, 32'h8, 1'b1);
    repeat (45) @(posedge clk);
    en <= 1'b0;
    repeat (8) @(posedge clk);
    chk("abort sending", snd, 1'b0);
    chk("abort line", up, 1'b0);
    axr(REG_COUNT);
    c = rd;
    chk("count kept", c != 0, 1'b1);
    repeat (40) @(posedge clk);
    axr(REG_COUNT);
    chk("count still", rd, c);
    chk("abort done", done, 1'b0);
    $display("test hold done");
  endtask : t_hold

  task automatic t_live();
    run(CTRL_RESET, RATE_MAX, 32'h64, 1'b1);
    axw(REG_RATE, 32'h03E8);
    repeat (100) @(posedge clk);
    chk("live rate", hw, 20);
    axw(REG_TARGET, 32'h1);
    wait_done();
    chk("live target", done, 1'b1);
    axr(REG_COUNT);
    chk("live count", rd < 32'h64, 1'b1);
    run(CTRL_RESET, RATE_MAX, 32'h0, 1'b1);
    repeat (200) @(posedge clk);
    chk("endless pulses", pos - p0 > 5, 1'b1);
    chk("endless sending", snd, 1'b1);
    chk("endless done", done, 1'b0);
    axr(REG_COUNT);
    chk("endless count", rd, 32'h0);
    $display("test live done");
  endtask : t_live

  task automatic t_err();
    logic [15:0] rt[7] = '{16'h0007, 16'h07D1, 16'h0008, 16'h07D0, 16'h07D0, 16'h07D0, 16'h07D0};
    logic [31:0] tg[7] = '{32'h5, 32'h5, 32'h5, 32'h7FFF, 32'h8000, 32'h8000, 32'h8000_0000};
    logic [3:0] cf[7] = '{4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'hE, 4'hE};
    logic ex[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    axw(REG_IMASK, 32'h1);
    axw(REG_ISTAT, 32'h3);
    for (int i = 0; i < 7; i++) begin
      run(cf[i], rt[i], tg[i], 1'b1);
      chk("error flag", err, ex[i]);
      chk("runs", snd, !ex[i]);
    end
    chk("irq masked", irq, 1'b0);
    axr(REG_ISTAT);
    chk("error event", rd[IRQ_ERR], 1'b1);
    axw(REG_IMASK, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq unmasked", irq, 1'b1);
    axw(REG_ISTAT, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq w1c", irq, 1'b0);
    $display("test err done");
  endtask : t_err

  // Main sequence
  initial begin
    {en, pause_in, ud, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    rstn = 1'b0;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_basic();
    t_outputs();
    t_hold();
    t_live();
    t_err();
    report_and_stop();
  end
endmodule : stepper_pulse_output_tb
